// [src/llc_pkg.sv]
// Package for the link-layer core control register block
package llc_pkg;
  // Register byte address
  localparam logic [31:0] LLC_MAIN_CTRL_ADDR = 32'h0400_0000;
  // Strobe bit positions
  localparam int LLC_CORE_RST_BIT = 31;
  localparam int LLC_TG_RST_BIT = 30;
  localparam int LLC_REG_RST_BIT = 29;
  localparam int LLC_RF_ABORT_BIT = 26;
  localparam int LLC_ADV_ABORT_BIT = 25;
  localparam int LLC_SCAN_ABORT_BIT = 24;
  // Mode bit positions
  localparam int LLC_MD_OVR_BIT = 22;
  localparam int LLC_SN_DIS_BIT = 21;
  localparam int LLC_NESN_DIS_BIT = 20;
  localparam int LLC_CRYPT_DIS_BIT = 19;
  localparam int LLC_WHIT_DIS_BIT = 18;
  localparam int LLC_CRC_DIS_BIT = 17;
  localparam int LLC_HOP_DIS_BIT = 16;
  // Strobe vector slots
  localparam int LLC_NUM_STB = 6;
  localparam int LLC_STB_CORE = 0;
  localparam int LLC_STB_TG = 1;
  localparam int LLC_STB_REG = 2;
  localparam int LLC_STB_RF = 3;
  localparam int LLC_STB_ADV = 4;
  localparam int LLC_STB_SCAN = 5;
  // Reset values
  localparam logic [5:0] LLC_STB_RST = 6'h00;
  localparam logic [31:0] LLC_RDATA_ZERO = 32'h0000_0000;
  // Transmit CRC fill when CRC handling is disabled
  localparam logic [23:0] LLC_CRC_TX_FILL = 24'h00_0000;
  // AHB encodings
  localparam logic [1:0] LLC_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] LLC_HRESP_OKAY = 2'h0;

  typedef struct packed {
    logic more_data_override;
    logic seq_num_disable;
    logic next_expected_seq_disable;
    logic encryption_disable;
    logic whitening_disable;
    logic crc_handling_disable;
    logic hop_remap_disable;
  } llc_mode_t;

  localparam llc_mode_t LLC_MODE_RST = '0;

  typedef enum logic [1:0] {
    LLC_AB_IDLE = 2'b00,
    LLC_AB_TX = 2'b01,
    LLC_AB_RX = 2'b10
  } llc_abort_st_t;
endpackage

// [src/llc_main_ctrl.sv]
// AHB-Lite register block for the link-layer core main control upper half
// Behaviour
// [R1] Bit 31 resets core, self-clears on done
// [R2] Bit 30 resets timing generator, self-clears
// [R3] Bit 29 resets whole register block, self-clears
// [R4] Bit 26 aborts RF test, self-clears
// [R5] Infinite transmit abort stops at byte end
// [R6] Infinite receive abort finishes packet or stops
// [R7] Bit 25 aborts advertising event, self-clears
// [R8] Bit 24 ends scan window, self-clears
// [R9] Bit 22 forces single exchange per event
// [R10] Bits 21/20 hand sequence bits to software
// [R11] Bit 19 disables cipher, MIC still generated
// [R12] Bit 18 bypasses data whitening
// [R13] Bit 17 keeps receive CRC, sends zero CRC
// [R14] Bit 16 skips channel remapping
// [R15] Reserved bits read zero, writes ignored
//
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/100ps
module llc_main_ctrl
  import llc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [1:0] hresp,
  output logic [31:0] hrdata,
  // Strobe requests and completions
  output logic core_soft_reset,
  output logic timing_gen_reset_strobe,
  output logic reg_block_reset,
  output logic rf_test_abort_strobe,
  output logic advertising_abort_strobe,
  output logic scan_abort_strobe,
  input wire logic core_reset_done,
  input wire logic timing_gen_reset_done,
  input wire logic adv_abort_done,
  input wire logic scan_abort_done,
  // Packet controller status for RF test abort
  input wire logic infinite_tx_active,
  input wire logic infinite_rx_active,
  input wire logic tx_byte_end,
  input wire logic access_addr_detected,
  input wire logic rx_packet_end,
  output logic tx_stop_crc_close,
  output logic rx_finish_stop,
  output logic rf_switch_off,
  // Mode controls
  input wire logic control_struct_encrypt_enable,
  input wire logic [23:0] crc_calc,
  output llc_mode_t mode,
  output logic payload_cipher_en,
  output logic mic_gen_en,
  output logic rx_crc_strip,
  output logic [23:0] crc_tx
);

  // Bus address phase capture
  logic wr_pend_ff, nxt_wr_pend;
  logic rd_pend_ff, nxt_rd_pend;
  logic hit_ff, nxt_hit;
  logic addr_ok;

  assign addr_ok = hsel && hready && (htrans == LLC_HTRANS_NONSEQ);

  always_comb begin
    nxt_wr_pend = addr_ok && hwrite;
    nxt_rd_pend = addr_ok && !hwrite;
    nxt_hit = addr_ok && (haddr == LLC_MAIN_CTRL_ADDR);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_pend_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
      hit_ff <= 1'b0;
    end else begin
      wr_pend_ff <= nxt_wr_pend;
      rd_pend_ff <= nxt_rd_pend;
      hit_ff <= nxt_hit;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = LLC_HRESP_OKAY;

  logic reg_wr;
  assign reg_wr = wr_pend_ff && hit_ff;

  // Strobe and mode registers
  logic [LLC_NUM_STB-1:0] stb_ff, nxt_stb;
  logic [LLC_NUM_STB-1:0] stb_wbit, stb_done;
  llc_mode_t mode_ff, nxt_mode;
  logic rf_done;

  assign stb_wbit = {hwdata[LLC_SCAN_ABORT_BIT], hwdata[LLC_ADV_ABORT_BIT],
                     hwdata[LLC_RF_ABORT_BIT], hwdata[LLC_REG_RST_BIT],
                     hwdata[LLC_TG_RST_BIT], hwdata[LLC_CORE_RST_BIT]};
  // Register reset completes in the cycle it is applied
  assign stb_done = {scan_abort_done, adv_abort_done, rf_done, 1'b1,
                     timing_gen_reset_done, core_reset_done};

  // Written one sets, written zero ignored; a new set beats done
  genvar gi;
  generate
    for (gi = 0; gi < LLC_NUM_STB; gi++) begin : g_stb
      always_comb begin
        nxt_stb[gi] = stb_ff[gi];
        if (stb_ff[gi] && stb_done[gi]) begin
          nxt_stb[gi] = 1'b0; // R1 R2 R4 R7 R8
        end
        if (reg_wr && stb_wbit[gi]) begin
          nxt_stb[gi] = 1'b1; // R1 R2 R3 R4 R7 R8
        end
        if (stb_ff[LLC_STB_REG]) begin
          nxt_stb[gi] = 1'b0; // R3
        end
      end
    end
  endgenerate

  always_comb begin
    nxt_mode = mode_ff;
    if (reg_wr) begin
      nxt_mode.more_data_override = hwdata[LLC_MD_OVR_BIT]; // R9
      nxt_mode.seq_num_disable = hwdata[LLC_SN_DIS_BIT]; // R10
      nxt_mode.next_expected_seq_disable = hwdata[LLC_NESN_DIS_BIT]; // R10
      nxt_mode.encryption_disable = hwdata[LLC_CRYPT_DIS_BIT]; // R11
      nxt_mode.whitening_disable = hwdata[LLC_WHIT_DIS_BIT]; // R12
      nxt_mode.crc_handling_disable = hwdata[LLC_CRC_DIS_BIT]; // R13
      nxt_mode.hop_remap_disable = hwdata[LLC_HOP_DIS_BIT]; // R14
    end
    if (stb_ff[LLC_STB_REG]) begin
      nxt_mode = LLC_MODE_RST; // R3
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stb_ff <= LLC_STB_RST;
      mode_ff <= LLC_MODE_RST;
    end else begin
      stb_ff <= nxt_stb;
      mode_ff <= nxt_mode;
    end
  end

  assign core_soft_reset = stb_ff[LLC_STB_CORE];
  assign timing_gen_reset_strobe = stb_ff[LLC_STB_TG];
  assign reg_block_reset = stb_ff[LLC_STB_REG];
  assign rf_test_abort_strobe = stb_ff[LLC_STB_RF];
  assign advertising_abort_strobe = stb_ff[LLC_STB_ADV];
  assign scan_abort_strobe = stb_ff[LLC_STB_SCAN];
  assign mode = mode_ff;

  // Read-back; unlisted bits stay zero
  always_comb begin
    hrdata = LLC_RDATA_ZERO;
    if (rd_pend_ff && hit_ff) begin
      hrdata[LLC_CORE_RST_BIT] = stb_ff[LLC_STB_CORE];
      hrdata[LLC_TG_RST_BIT] = stb_ff[LLC_STB_TG];
      hrdata[LLC_REG_RST_BIT] = stb_ff[LLC_STB_REG];
      hrdata[LLC_RF_ABORT_BIT] = stb_ff[LLC_STB_RF];
      hrdata[LLC_ADV_ABORT_BIT] = stb_ff[LLC_STB_ADV];
      hrdata[LLC_SCAN_ABORT_BIT] = stb_ff[LLC_STB_SCAN];
      hrdata[LLC_MD_OVR_BIT] = mode_ff.more_data_override;
      hrdata[LLC_SN_DIS_BIT] = mode_ff.seq_num_disable;
      hrdata[LLC_NESN_DIS_BIT] = mode_ff.next_expected_seq_disable;
      hrdata[LLC_CRYPT_DIS_BIT] = mode_ff.encryption_disable;
      hrdata[LLC_WHIT_DIS_BIT] = mode_ff.whitening_disable;
      hrdata[LLC_CRC_DIS_BIT] = mode_ff.crc_handling_disable;
      hrdata[LLC_HOP_DIS_BIT] = mode_ff.hop_remap_disable; // R15
    end
  end

  // RF test abort sequencing
  llc_abort_st_t ab_st_ff, nxt_ab_st;
  logic tx_stop_ff, nxt_tx_stop;
  logic rx_fin_ff, nxt_rx_fin;
  logic rf_off_ff, nxt_rf_off;

  always_comb begin
    nxt_ab_st = ab_st_ff;
    nxt_tx_stop = 1'b0;
    nxt_rx_fin = 1'b0;
    nxt_rf_off = 1'b0;
    rf_done = 1'b0;
    case (ab_st_ff)
      LLC_AB_IDLE: begin
        if (stb_ff[LLC_STB_RF]) begin
          if (infinite_tx_active) begin
            nxt_ab_st = LLC_AB_TX; // R5
          end else if (infinite_rx_active && access_addr_detected) begin
            nxt_ab_st = LLC_AB_RX; // R6
          end else if (infinite_rx_active) begin
            nxt_rf_off = 1'b1; // R6
            rf_done = 1'b1;
          end else begin
            rf_done = 1'b1; // R4
          end
        end
      end
      LLC_AB_TX: begin
        if (tx_byte_end) begin
          nxt_tx_stop = 1'b1; // R5
          rf_done = 1'b1;
          nxt_ab_st = LLC_AB_IDLE;
        end
      end
      LLC_AB_RX: begin
        if (rx_packet_end) begin
          nxt_rx_fin = 1'b1; // R6
          rf_done = 1'b1;
          nxt_ab_st = LLC_AB_IDLE;
        end
      end
      default: begin
        nxt_ab_st = LLC_AB_IDLE;
      end
    endcase
    if (stb_ff[LLC_STB_REG]) begin
      nxt_ab_st = LLC_AB_IDLE;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ab_st_ff <= LLC_AB_IDLE;
      tx_stop_ff <= 1'b0;
      rx_fin_ff <= 1'b0;
      rf_off_ff <= 1'b0;
    end else begin
      ab_st_ff <= nxt_ab_st;
      tx_stop_ff <= nxt_tx_stop;
      rx_fin_ff <= nxt_rx_fin;
      rf_off_ff <= nxt_rf_off;
    end
  end

  assign tx_stop_crc_close = tx_stop_ff;
  assign rx_finish_stop = rx_fin_ff;
  assign rf_switch_off = rf_off_ff;

  // Datapath effects of mode bits
  logic cipher_ff, nxt_cipher;
  logic mic_ff, nxt_mic;
  logic strip_ff, nxt_strip;
  logic [23:0] crc_tx_ff, nxt_crc_tx;

  always_comb begin
    nxt_cipher = control_struct_encrypt_enable &&
                 !mode_ff.encryption_disable; // R11
    nxt_mic = control_struct_encrypt_enable; // R11
    nxt_strip = !mode_ff.crc_handling_disable; // R13
    nxt_crc_tx = mode_ff.crc_handling_disable ? LLC_CRC_TX_FILL
                                              : crc_calc; // R13
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cipher_ff <= 1'b0;
      mic_ff <= 1'b0;
      strip_ff <= 1'b1;
      crc_tx_ff <= LLC_CRC_TX_FILL;
    end else begin
      cipher_ff <= nxt_cipher;
      mic_ff <= nxt_mic;
      strip_ff <= nxt_strip;
      crc_tx_ff <= nxt_crc_tx;
    end
  end

  assign payload_cipher_en = cipher_ff;
  assign mic_gen_en = mic_ff;
  assign rx_crc_strip = strip_ff;
  assign crc_tx = crc_tx_ff;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  core_rst_set_a: assert property ( // R1
    reg_wr && hwdata[LLC_CORE_RST_BIT] && !stb_ff[LLC_STB_REG]
    |=> core_soft_reset)
    else $error("core reset strobe not set by write");
  core_rst_hold_a: assert property ( // R1
    core_soft_reset && !core_reset_done && !reg_block_reset
    |=> core_soft_reset)
    else $error("core reset strobe dropped before done");
  tg_rst_clr_a: assert property ( // R2
    timing_gen_reset_strobe && timing_gen_reset_done && !reg_wr
    |=> !timing_gen_reset_strobe)
    else $error("timing reset strobe did not clear");
  reg_rst_pulse_a: assert property ( // R3
    reg_block_reset |=> !reg_block_reset && mode == LLC_MODE_RST)
    else $error("register block reset not one cycle");
  rf_tx_stop_a: assert property ( // R5
    ab_st_ff == LLC_AB_TX && tx_byte_end |=> tx_stop_crc_close)
    else $error("tx abort did not stop at byte end");
  rf_rx_off_a: assert property ( // R6
    ab_st_ff == LLC_AB_IDLE && rf_test_abort_strobe && !infinite_tx_active
    && infinite_rx_active && !access_addr_detected |=> rf_switch_off)
    else $error("rx abort did not switch rf off");
  scan_clr_a: assert property ( // R8
    scan_abort_strobe && scan_abort_done && !reg_wr
    |=> !scan_abort_strobe)
    else $error("scan abort strobe did not clear");
  md_write_a: assert property ( // R9
    reg_wr && !reg_block_reset
    |=> mode.more_data_override == $past(hwdata[LLC_MD_OVR_BIT]))
    else $error("more data override not written");
  cipher_off_a: assert property ( // R11
    mode.encryption_disable |=> !payload_cipher_en)
    else $error("cipher enabled while disabled");
  crc_fill_a: assert property ( // R13
    mode.crc_handling_disable |=> crc_tx == LLC_CRC_TX_FILL && !rx_crc_strip)
    else $error("crc fill not applied");
  rsvd_zero_a: assert property ( // R15
    hrdata[28:27] == 2'h0 && hrdata[23] == 1'b0 && hrdata[15:0] == 16'h0000)
    else $error("reserved bits read nonzero");

endmodule // llc_main_ctrl

// [verif/llc_main_ctrl_tb_top.sv]
// Self-checking bench for the link-layer core main control block
`timescale 1ns/100ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_total++; \
  $display("MISMATCH %s exp=%0h got=%0h", n, e, g); end end
module llc_main_ctrl_tb_top
  import llc_pkg::*;
;
  typedef struct packed {
    logic [31:0] a;
    logic [31:0] d;
    logic [31:0] e;
  } llc_row_t;
  logic clk, sys_rst, hsel, hwrite, hready, hreadyout;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, hresp;
  logic [2:0] hsize;
  logic core_soft_reset, timing_gen_reset_strobe, reg_block_reset;
  logic rf_test_abort_strobe, advertising_abort_strobe, scan_abort_strobe;
  logic [3:0] done_v;
  logic infinite_tx_active, infinite_rx_active, tx_byte_end;
  logic access_addr_detected, rx_packet_end;
  logic tx_stop_crc_close, rx_finish_stop, rf_switch_off;
  logic control_struct_encrypt_enable, payload_cipher_en, mic_gen_en;
  logic rx_crc_strip;
  logic [23:0] crc_calc, crc_tx;
  llc_mode_t mode;
  int err_total = 0;
  int compares = 0;
  int pc[3] = '{0, 0, 0};
  int sbit[4] = '{24, 25, 30, 31};
  wire [3:0] stb_v = {core_soft_reset, timing_gen_reset_strobe,
    advertising_abort_strobe, scan_abort_strobe};
  llc_row_t rows[5] = '{
    '{LLC_MAIN_CTRL_ADDR, 32'h007F_0000, 32'h007F_0000},
    '{32'h0400_0004, 32'h0055_0000, 32'h007F_0000},
    '{LLC_MAIN_CTRL_ADDR, 32'h1880_FFFF, 32'h0000_0000},
    '{LLC_MAIN_CTRL_ADDR, 32'h0055_0000, 32'h0055_0000},
    '{LLC_MAIN_CTRL_ADDR, 32'h002A_0000, 32'h002A_0000}};

  assign hready = hreadyout;

  llc_main_ctrl dut_u (
    .clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .core_soft_reset(core_soft_reset),
    .timing_gen_reset_strobe(timing_gen_reset_strobe),
    .reg_block_reset(reg_block_reset),
    .rf_test_abort_strobe(rf_test_abort_strobe),
    .advertising_abort_strobe(advertising_abort_strobe),
    .scan_abort_strobe(scan_abort_strobe),
    .core_reset_done(done_v[3]), .timing_gen_reset_done(done_v[2]),
    .adv_abort_done(done_v[1]), .scan_abort_done(done_v[0]),
    .infinite_tx_active(infinite_tx_active),
    .infinite_rx_active(infinite_rx_active), .tx_byte_end(tx_byte_end),
    .access_addr_detected(access_addr_detected),
    .rx_packet_end(rx_packet_end), .tx_stop_crc_close(tx_stop_crc_close),
    .rx_finish_stop(rx_finish_stop), .rf_switch_off(rf_switch_off),
    .control_struct_encrypt_enable(control_struct_encrypt_enable),
    .crc_calc(crc_calc), .mode(mode), .payload_cipher_en(payload_cipher_en),
    .mic_gen_en(mic_gen_en), .rx_crc_strip(rx_crc_strip), .crc_tx(crc_tx)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Counts each one-cycle abort pulse
  always @(posedge clk) begin
    pc[0] <= pc[0] + int'(tx_stop_crc_close);
    pc[1] <= pc[1] + int'(rx_finish_stop);
    pc[2] <= pc[2] + int'(rf_switch_off);
  end

  // Waits for hready high at a rising edge; only the watchdog ends a hang
  task automatic ahb_wait;
    @(posedge clk);
    while (hreadyout !== 1'b1) begin
      @(posedge clk);
    end
  endtask

  // One single word transfer; read data lands in rd
  task automatic ahb_go(input logic [31:0] a, input logic w,
                        input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    htrans <= LLC_HTRANS_NONSEQ;
    ahb_wait();
    htrans <= 2'h0;
    hwdata <= d;
    ahb_wait();
    rd = hrdata;
  endtask

  task automatic rf_case(input logic tx, input logic rx, input logic aa,
                         input logic [2:0] exp);
    int b[3];
    @(posedge clk);
    infinite_tx_active <= tx;
    infinite_rx_active <= rx;
    access_addr_detected <= aa;
    b = pc;
    ahb_go(LLC_MAIN_CTRL_ADDR, 1'b1, 32'h0400_0000);
    repeat (3) @(posedge clk);
    #1;
    if (tx || aa) begin
      `CHK("abort waits", 4'h8, {rf_test_abort_strobe, pc[2] != b[2],
        pc[1] != b[1], pc[0] != b[0]})
      @(posedge clk);
      tx_byte_end <= tx;
      rx_packet_end <= !tx;
      @(posedge clk);
      tx_byte_end <= 1'b0;
      rx_packet_end <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
    end
    `CHK("abort pulses", {1'b0, exp}, {rf_test_abort_strobe,
      pc[2] != b[2], pc[1] != b[1], pc[0] != b[0]})
  endtask

  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Whole run is about 150 cycles; this is ample margin
  initial begin
    #20000;
    err_total++;
    tally_and_finish();
  end

  initial begin
    {sys_rst, hsel, hwrite, done_v} = 7'h40;
    {haddr, hwdata, htrans, hsize} = '0;
    {infinite_tx_active, infinite_rx_active, tx_byte_end} = 3'h0;
    {access_addr_detected, rx_packet_end} = 2'h0;
    control_struct_encrypt_enable = 1'b1;
    crc_calc = 24'hABCDEF;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    `CHK("reset strobes", 5'h00, {stb_v, reg_block_reset})
    `CHK("reset mode", LLC_MODE_RST, mode)
    `CHK("reset crc", {1'b1, 24'h0}, {rx_crc_strip, crc_tx})
    for (int i = 0; i < 5; i++) begin
      ahb_go(rows[i].a, 1'b1, rows[i].d);
      @(posedge clk);
      #1;
      `CHK("mode", rows[i].e[22:16], 7'(mode))
      `CHK("cipher", ~rows[i].e[19], payload_cipher_en)
      `CHK("mic", 1'b1, mic_gen_en)
      `CHK("strip", ~rows[i].e[17], rx_crc_strip)
      `CHK("crc_tx", rows[i].e[17] ? 24'h0 : crc_calc, crc_tx)
      ahb_go(LLC_MAIN_CTRL_ADDR, 1'b0, 32'h0);
      `CHK("readback", rows[i].e, rd)
    end
    ahb_go(32'h0400_0004, 1'b0, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    `CHK("resp", {1'b1, LLC_HRESP_OKAY}, {hreadyout, hresp})
    control_struct_encrypt_enable <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    `CHK("mic off", 2'h0, {mic_gen_en, payload_cipher_en})
    @(posedge clk);
    control_struct_encrypt_enable <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      ahb_go(LLC_MAIN_CTRL_ADDR, 1'b1, 32'h1 << sbit[i]);
      #1;
      `CHK("strobe set", 4'h1 << i, stb_v)
      ahb_go(LLC_MAIN_CTRL_ADDR, 1'b1, 32'h0);
      #1;
      `CHK("zero ignored", 4'h1 << i, stb_v)
      ahb_go(LLC_MAIN_CTRL_ADDR, 1'b0, 32'h0);
      `CHK("strobe read", 32'h1 << sbit[i], rd)
      @(posedge clk);
      done_v[i] <= 1'b1;
      @(posedge clk);
      done_v[i] <= 1'b0;
      #1;
      `CHK("strobe clear", 4'h0, stb_v)
    end
    // Block reset must override a pending strobe and the mode bits written along with it
    ahb_go(LLC_MAIN_CTRL_ADDR, 1'b1, 32'h0100_0000);
    ahb_go(LLC_MAIN_CTRL_ADDR, 1'b1, 32'h207F_0000);
    #1;
    `CHK("blk rst pulse", 1'b1, reg_block_reset)
    @(posedge clk);
    #1;
    `CHK("blk rst done", 12'h0, {reg_block_reset, stb_v, 7'(mode)})
    rf_case(1'b1, 1'b0, 1'b0, 3'b001);
    rf_case(1'b0, 1'b1, 1'b1, 3'b010);
    rf_case(1'b0, 1'b1, 1'b0, 3'b100);
    rf_case(1'b0, 1'b0, 1'b0, 3'b000);
    rf_case(1'b1, 1'b1, 1'b1, 3'b001);
    tally_and_finish();
  end
endmodule // llc_main_ctrl_tb_top
